// File: src/gimi_unit.sv
// Guest interrupt, task switch, freeze, shutdown and pause intercept logic.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "gimi_defs.svh"

// Operation
// - Intercepted external interrupt exits and stays pending for later.
// - External and software interrupts never check exception intercepts.
// - Maskable intercept covers physical interrupts; virtual ones separate.
// - NMI/SMI may wait one instruction after interrupt enable set.
// - SMI exit bit 0: 0 internal I/O trap, 1 external.
// - SMI during I/O: describe it in upper half, valid bit 33.
// - SMI during I/O: second exit word holds instruction pointer.
// - SMI outside I/O: extra bits of both words undefined.
// - SMI intercept ignored while system-management lock bit set.
// - Port 63-48, breakpoints 47-44, trap 43, 42 zero, sizes.
// - Repeat 35, string 34, direction 32, segment 12-10.
// - Virtual interrupt exit before taking it; request stays pending.
// - Task intercept after segment checks, before any state change.
// - Task switch tests only its dedicated intercept bit.
// - Task exit: selector 15-0 first word, error code second word.
// - Task exit: bit 36 interrupt return, bit 38 far jump.
// - Task exit: bit 44 error code present, bit 48 resume flag.
// - Float-error freeze intercept checked while frozen awaiting interrupt.
// - Shutdown intercept turns every shutdown into a guest exit.
// - Entry loads pause count; pause decrements; exit at zero.
// - Advanced: elapsed above threshold reloads, below decrements.
// - Zero threshold behaves as simple count-only filter.
// - Hidden-state save/load: fault outside level zero, or unenabled.
module gimi_unit
   import gimi_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // APB register slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Guest event stream: one-cycle pulses plus the qualifiers and data that go with them.
   input wire logic guest_entry_in,
   input wire logic ext_int_in,
   input wire logic physical_maskable_interrupt_in,
   input wire logic nmi_in,
   input wire logic smi_in,
   input wire logic smi_external_in,
   input wire logic smi_in_io_in,
   input wire gimi_io_s smi_io_in,
   input wire logic init_in,
   input wire logic virt_int_in,
   input wire logic task_switch_in,
   input wire gimi_task_s task_in,
   input wire logic ferr_freeze_in,
   input wire logic ignore_float_error_input,
   input wire logic legacy_ferr_in,
   input wire logic shutdown_in,
   input wire logic pause_in,
   input wire logic interrupt_enable_set_instruction_in,
   input wire logic hidden_state_op_in,
   // Core state levels.
   input wire logic sysmgmt_lock_bit_in,
   input wire logic [1:0] current_privilege_level_in,
   input wire logic protected_mode_in,
   input wire logic virtualization_enable_bit_in,
   // Results toward the core.
   output gimi_exit_s exit_out,
   output logic take_int_out,
   output logic ext_int_pending_out,
   output logic virt_int_pending_out,
   output logic shutdown_out,
   output gimi_fault_e fault_out
);
   logic [`GIMI_CTRL_W-1:0] ctrl_q;
   logic [15:0] pfc_q;
   logic [15:0] pft_q;
   logic [31:0] cyc_q;
   logic signed [`GIMI_CNT_W-1:0] cnt_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   gimi_exit_s exit_q;
   logic take_int_q;
   logic ext_pend_q;
   logic virt_pend_q;
   logic shut_q;
   gimi_fault_e fault_q;
   logic hold_q;
   logic held_nmi_q;
   logic held_smi_q;
   logic held_smi_ext_q;
   logic held_smi_io_q;
   gimi_io_s held_io_q;

   // Decode shared by read and write paths.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   wire acc = psel_in && penable_in && !pready_q;
   wire wr = acc && pwrite_in;
   wire rd_map = hit(paddr_in, `GIMI_OFF_CTRL) ||
      hit(paddr_in, `GIMI_OFF_STAT) || hit(paddr_in, `GIMI_OFF_PFC) ||
      hit(paddr_in, `GIMI_OFF_PFT) || hit(paddr_in, `GIMI_OFF_EW1_LO) ||
      hit(paddr_in, `GIMI_OFF_EW1_HI) || hit(paddr_in, `GIMI_OFF_EW2_LO) ||
      hit(paddr_in, `GIMI_OFF_EW2_HI) || hit(paddr_in, `GIMI_OFF_CYC) ||
      hit(paddr_in, `GIMI_OFF_CNT);
   wire wr_map = hit(paddr_in, `GIMI_OFF_CTRL) ||
      hit(paddr_in, `GIMI_OFF_PFC) || hit(paddr_in, `GIMI_OFF_PFT);
   wire map_ok = pwrite_in ? wr_map : rd_map;

   wire [31:0] rd_val =
      hit(paddr_in, `GIMI_OFF_CTRL) ? {22'h0, ctrl_q} :
      hit(paddr_in, `GIMI_OFF_STAT) ? {20'h0, fault_q, shut_q, virt_pend_q,
         ext_pend_q, hold_q, exit_q.valid, exit_q.code, 1'b0} :
      hit(paddr_in, `GIMI_OFF_PFC) ? {16'h0, pfc_q} :
      hit(paddr_in, `GIMI_OFF_PFT) ? {16'h0, pft_q} :
      hit(paddr_in, `GIMI_OFF_EW1_LO) ? exit_q.first_exit_word[31:0] :
      hit(paddr_in, `GIMI_OFF_EW1_HI) ? exit_q.first_exit_word[63:32] :
      hit(paddr_in, `GIMI_OFF_EW2_LO) ? exit_q.second_exit_word[31:0] :
      hit(paddr_in, `GIMI_OFF_EW2_HI) ? exit_q.second_exit_word[63:32] :
      hit(paddr_in, `GIMI_OFF_CYC) ? cyc_q :
      hit(paddr_in, `GIMI_OFF_CNT) ? {{15{cnt_q[`GIMI_CNT_W-1]}}, cnt_q} :
      32'h0;

   // NMI and SMI held off for one instruction after interrupt enable set.
   wire nmi_now = (nmi_in && !hold_q) || held_nmi_q;
   wire smi_now = (smi_in && !hold_q) || held_smi_q;
   wire smi_ext = held_smi_q ? held_smi_ext_q : smi_external_in;
   wire smi_io = held_smi_q ? held_smi_io_q : smi_in_io_in;
   gimi_io_s io_sel;
   assign io_sel = held_smi_q ? held_io_q : smi_io_in;

   // Only the dedicated enables are consulted, never exception vectors.
   wire x_ext = ext_int_in && ctrl_q[`GIMI_C_EXTINT];
   wire x_pmi = physical_maskable_interrupt_in && ctrl_q[`GIMI_C_PMI];
   wire x_nmi = nmi_now && ctrl_q[`GIMI_C_NMI];
   wire x_smi = smi_now && ctrl_q[`GIMI_C_SMI] && !sysmgmt_lock_bit_in;
   wire x_init = init_in && ctrl_q[`GIMI_C_INIT];
   wire x_vint = virt_int_in && ctrl_q[`GIMI_C_VINT];
   // Core raises the request after gate checks, before state changes.
   wire x_task = task_switch_in && ctrl_q[`GIMI_C_TASK];
   wire x_ferr = ferr_freeze_in && !ignore_float_error_input &&
      legacy_ferr_in && ctrl_q[`GIMI_C_FERR];
   wire x_shut = shutdown_in && ctrl_q[`GIMI_C_SHUT];

   // Pause filtering.
   wire adv = (pft_q != 16'h0);
   wire slow = adv && (cyc_q > {16'h0, pft_q});
   wire [`GIMI_CNT_W-1:0] reload = {1'b0, pfc_q};
   wire [`GIMI_CNT_W-1:0] dec = cnt_q - `GIMI_CNT_W'(1);
   wire x_pause_s = pause_in && !adv && ctrl_q[`GIMI_C_PAUSE] &&
      (cnt_q <= `GIMI_CNT_W'(1));
   wire x_pause_a = pause_in && adv && !slow && ctrl_q[`GIMI_C_PAUSE] &&
      dec[`GIMI_CNT_W-1];
   wire x_pause = x_pause_s || x_pause_a;
   wire [`GIMI_CNT_W-1:0] cnt_d = guest_entry_in ? reload :
      !pause_in ? cnt_q :
      slow ? reload :
      (!adv && cnt_q == `GIMI_CNT_W'(0)) ? cnt_q : dec;

   // Exit information words.
   wire [63:0] smi_w1 = smi_io ? {io_sel.port, io_sel.brk_match,
      io_sel.trap_flag_copy, 1'b0, io_sel.addr_size, io_sel.operand_size,
      io_sel.repeated_access_bit, io_sel.string_access_bit, 1'b1,
      io_sel.is_input, 19'h0, io_sel.effective_segment_field, 9'h0,
      smi_ext} : {63'h0, smi_ext};
   wire [63:0] smi_w2 = smi_io ? io_sel.instruction_pointer : 64'h0;
   wire [63:0] ts_w1 = {48'h0, task_in.selector};
   wire [63:0] ts_w2 = {15'h0, task_in.resume_flag, 3'h0, task_in.has_error,
      5'h0, task_in.by_far_jump, 1'b0, task_in.by_interrupt_return_instruction, 4'h0,
      task_in.has_error ? task_in.error_code : 32'h0};

   gimi_exit_e code_d;
   assign code_d = x_shut ? GIMI_EX_SHUT : x_smi ? GIMI_EX_SMI :
      x_init ? GIMI_EX_INIT : x_nmi ? GIMI_EX_NMI :
      x_ext ? GIMI_EX_EXTINT : x_pmi ? GIMI_EX_PMI :
      x_ferr ? GIMI_EX_FERR : x_task ? GIMI_EX_TASK :
      x_vint ? GIMI_EX_VINT : x_pause ? GIMI_EX_PAUSE : GIMI_EX_NONE;
   gimi_exit_s exit_d;
   assign exit_d.valid = (code_d != GIMI_EX_NONE);
   assign exit_d.code = code_d;
   assign exit_d.first_exit_word = (code_d == GIMI_EX_SMI) ? smi_w1 :
      (code_d == GIMI_EX_TASK) ? ts_w1 : 64'h0;
   assign exit_d.second_exit_word = (code_d == GIMI_EX_SMI) ? smi_w2 :
      (code_d == GIMI_EX_TASK) ? ts_w2 : 64'h0;

   // A non-intercepted external, maskable or virtual interrupt is delivered to the guest when no exit is raised.
   wire take_d = ((ext_int_in && !x_ext) ||
      (physical_maskable_interrupt_in && !x_pmi) ||
      (virt_int_in && !x_vint)) && !exit_d.valid;

   gimi_fault_e fault_d;
   assign fault_d = !hidden_state_op_in ? GIMI_FLT_NONE :
      (!protected_mode_in || !virtualization_enable_bit_in) ? GIMI_FLT_UD :
      (current_privilege_level_in != 2'b00) ? GIMI_FLT_GP :
      GIMI_FLT_NONE;

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_q <= '0;
         pfc_q <= 16'h0;
         pft_q <= 16'h0;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !map_ok;
         prdata_q <= (acc && !pwrite_in) ? rd_val : 32'h0;
         if (wr && hit(paddr_in, `GIMI_OFF_CTRL)) begin
            ctrl_q <= pwdata_in[`GIMI_CTRL_W-1:0];
         end
         if (wr && hit(paddr_in, `GIMI_OFF_PFC)) begin
            pfc_q <= pwdata_in[15:0];
         end
         if (wr && hit(paddr_in, `GIMI_OFF_PFT)) begin
            pft_q <= pwdata_in[15:0];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cyc_q <= 32'h0;
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         if (pause_in || guest_entry_in) begin
            cyc_q <= 32'h1;
         end else if (cyc_q != 32'hffffffff) begin
            cyc_q <= cyc_q + 32'h1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_q <= 1'b0;
         held_nmi_q <= 1'b0;
         held_smi_q <= 1'b0;
         held_smi_ext_q <= 1'b0;
         held_smi_io_q <= 1'b0;
         held_io_q <= '0;
      end else begin
         hold_q <= interrupt_enable_set_instruction_in;
         held_nmi_q <= nmi_in && hold_q;
         held_smi_q <= smi_in && hold_q;
         held_smi_ext_q <= smi_external_in;
         held_smi_io_q <= smi_in_io_in;
         held_io_q <= smi_io_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         exit_q <= '0;
         take_int_q <= 1'b0;
         ext_pend_q <= 1'b0;
         virt_pend_q <= 1'b0;
         shut_q <= 1'b0;
         fault_q <= GIMI_FLT_NONE;
      end else begin
         exit_q.valid <= exit_d.valid;
         exit_q.code <= code_d;
         if (exit_d.valid) begin
            exit_q.first_exit_word <= exit_d.first_exit_word;
            exit_q.second_exit_word <= exit_d.second_exit_word;
         end
         take_int_q <= take_d;
         ext_pend_q <= x_ext || (ext_pend_q && !guest_entry_in);
         virt_pend_q <= x_vint || (virt_pend_q && !take_d);
         shut_q <= shutdown_in && !ctrl_q[`GIMI_C_SHUT];
         fault_q <= fault_d;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign exit_out = exit_q;
   assign take_int_out = take_int_q;
   assign ext_int_pending_out = ext_pend_q;
   assign virt_int_pending_out = virt_pend_q;
   assign shutdown_out = shut_q;
   assign fault_out = fault_q;
endmodule : gimi_unit

// File: src/gimi_defs.svh
// Constant definitions for the guest interrupt and miscellaneous intercept unit.
`ifndef GIMI_DEFS_SVH
`define GIMI_DEFS_SVH
`define GIMI_APB_AW 8
`define GIMI_OFF_CTRL 8'h00
`define GIMI_OFF_STAT 8'h04
`define GIMI_OFF_PFC 8'h08
`define GIMI_OFF_PFT 8'h0c
`define GIMI_OFF_EW1_LO 8'h10
`define GIMI_OFF_EW1_HI 8'h14
`define GIMI_OFF_EW2_LO 8'h18
`define GIMI_OFF_EW2_HI 8'h1c
`define GIMI_OFF_CYC 8'h20
`define GIMI_OFF_CNT 8'h24
`define GIMI_CTRL_W 10
`define GIMI_C_EXTINT 0
`define GIMI_C_PMI 1
`define GIMI_C_NMI 2
`define GIMI_C_SMI 3
`define GIMI_C_INIT 4
`define GIMI_C_VINT 5
`define GIMI_C_TASK 6
`define GIMI_C_FERR 7
`define GIMI_C_SHUT 8
`define GIMI_C_PAUSE 9
`define GIMI_SYSMGMT_SOURCE_BIT_BIT 0
`define GIMI_SEG_LO 10
`define GIMI_VAL_BIT 33
`define GIMI_TS_INTERRUPT_RETURN_INSTRUCTION_BIT 36
`define GIMI_TS_JMP_BIT 38
`define GIMI_TS_ERR_BIT 44
`define GIMI_TS_RF_BIT 48
`define GIMI_CNT_W 17
`endif

// File: src/gimi_pkg.sv
// Types for the guest interrupt and miscellaneous intercept unit.
package gimi_pkg;
   typedef enum logic [3:0] {
      GIMI_EX_NONE = 4'h0,
      GIMI_EX_EXTINT = 4'h1,
      GIMI_EX_PMI = 4'h2,
      GIMI_EX_NMI = 4'h3,
      GIMI_EX_SMI = 4'h4,
      GIMI_EX_INIT = 4'h5,
      GIMI_EX_VINT = 4'h6,
      GIMI_EX_TASK = 4'h7,
      GIMI_EX_FERR = 4'h8,
      GIMI_EX_SHUT = 4'h9,
      GIMI_EX_PAUSE = 4'ha
   } gimi_exit_e;
   typedef enum logic [1:0] {
      GIMI_FLT_NONE = 2'b00,
      GIMI_FLT_GP = 2'b01,
      GIMI_FLT_UD = 2'b10
   } gimi_fault_e;
   typedef struct packed {
      logic [15:0] port;
      logic [3:0] brk_match;
      logic trap_flag_copy;
      logic [2:0] addr_size;
      logic [2:0] operand_size;
      logic repeated_access_bit;
      logic string_access_bit;
      logic is_input;
      logic [2:0] effective_segment_field;
      logic [63:0] instruction_pointer;
   } gimi_io_s;
   typedef struct packed {
      logic [15:0] selector;
      logic [31:0] error_code;
      logic has_error;
      logic by_interrupt_return_instruction;
      logic by_far_jump;
      logic resume_flag;
   } gimi_task_s;
   typedef struct packed {
      logic valid;
      gimi_exit_e code;
      logic [63:0] first_exit_word;
      logic [63:0] second_exit_word;
   } gimi_exit_s;
endpackage : gimi_pkg

// File: verification/gimi_unit_monitor.sv
// Property checker for the guest intercept unit.
`timescale 1ns/1ps
module gimi_monitor
   import gimi_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Watched inputs.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic smi_in,
   input wire logic smi_external_in,
   input wire logic smi_in_io_in,
   input wire gimi_io_s smi_io_in,
   input wire gimi_task_s task_in,
   input wire logic sysmgmt_lock_bit_in,
   input wire logic hidden_state_op_in,
   input wire logic protected_mode_in,
   input wire logic virtualization_enable_bit_in,
   input wire logic [1:0] current_privilege_level_in,
   // Watched outputs.
   input wire logic pready_out,
   input wire gimi_exit_s exit_out,
   input wire logic ext_int_pending_out,
   input wire logic virt_int_pending_out,
   input wire logic take_int_out,
   input wire logic shutdown_out,
   input wire gimi_fault_e fault_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   gimi_io_s io_q;
   gimi_task_s tk_q;
   logic smi_q, ext_q, inio_q;
   wire ok_mode = protected_mode_in && virtualization_enable_bit_in;
   wire ex_smi = exit_out.valid && exit_out.code == GIMI_EX_SMI;
   wire ex_task = exit_out.valid && exit_out.code == GIMI_EX_TASK;
   always_ff @(posedge core_clk_in) begin
      io_q <= smi_io_in;
      tk_q <= task_in;
      smi_q <= smi_in;
      ext_q <= smi_external_in;
      inio_q <= smi_in_io_in;
   end
   apb_wait_a: assert property (psel_in && penable_in && !pready_out
      |=> pready_out) else $error("APB answer not after one wait");
   smi_lock_a: assert property (
      smi_in && sysmgmt_lock_bit_in |=> (!ex_smi)[*2])
      else $error("Locked SMI still exited");
   smi_source_a: assert property (
      ex_smi && smi_q |-> exit_out.first_exit_word[0] == ext_q)
      else $error("SMI source bit wrong");
   smi_io_a: assert property (
      ex_smi && smi_q && inio_q |-> exit_out.first_exit_word[33]
      && exit_out.first_exit_word[63:48] == io_q.port
      && exit_out.second_exit_word == io_q.instruction_pointer)
      else $error("SMI I/O description wrong");
   task_sel_a: assert property (
      ex_task |-> exit_out.first_exit_word[15:0] == tk_q.selector)
      else $error("Task selector wrong");
   task_flags_a: assert property (
      ex_task |-> exit_out.second_exit_word[36] == tk_q.by_interrupt_return_instruction
      && exit_out.second_exit_word[38] == tk_q.by_far_jump
      && exit_out.second_exit_word[44] == tk_q.has_error
      && exit_out.second_exit_word[48] == tk_q.resume_flag)
      else $error("Task flag bits wrong");
   fault_ud_a: assert property (
      hidden_state_op_in && !ok_mode |=> fault_out == GIMI_FLT_UD)
      else $error("Invalid opcode fault missing");
   fault_gp_a: assert property (
      hidden_state_op_in && ok_mode && current_privilege_level_in != 2'h0
      |=> fault_out == GIMI_FLT_GP) else $error("Protection fault missing");
   ext_pend_a: assert property (
      exit_out.valid && exit_out.code == GIMI_EX_EXTINT
      |-> ext_int_pending_out) else $error("External not kept pending");
   vint_pend_a: assert property (
      exit_out.valid && exit_out.code == GIMI_EX_VINT
      |-> virt_int_pending_out && !take_int_out)
      else $error("Virtual interrupt taken");
   shut_exit_a: assert property (
      exit_out.valid && exit_out.code == GIMI_EX_SHUT |-> !shutdown_out)
      else $error("Intercepted shutdown still shut down");
endmodule : gimi_monitor

bind gimi_unit gimi_monitor gimi_monitor_inst (
   .core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
   .penable_in(penable_in), .smi_in(smi_in),
   .smi_external_in(smi_external_in), .smi_in_io_in(smi_in_io_in),
   .smi_io_in(smi_io_in), .task_in(task_in),
   .sysmgmt_lock_bit_in(sysmgmt_lock_bit_in),
   .hidden_state_op_in(hidden_state_op_in),
   .protected_mode_in(protected_mode_in),
   .virtualization_enable_bit_in(virtualization_enable_bit_in),
   .current_privilege_level_in(current_privilege_level_in),
   .pready_out(pready_out), .exit_out(exit_out),
   .ext_int_pending_out(ext_int_pending_out),
   .virt_int_pending_out(virt_int_pending_out),
   .take_int_out(take_int_out), .shutdown_out(shutdown_out),
   .fault_out(fault_out)
);

// File: verification/test_guest_interrupt_misc_intercepts.sv
// Self-checking bench for the guest intercept unit.
`timescale 1ns/1ps
`include "gimi_defs.svh"
module test_guest_interrupt_misc_intercepts import gimi_pkg::*;;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, take, extp, virtp, shut;
   logic [12:0] ev = 13'h0;
   logic ext_src = 1'b0, in_io = 1'b0, lock = 1'b0;
   logic prot = 1'b1, virt = 1'b1;
   logic [1:0] current_privilege_level = 2'h0;
   gimi_io_s io = '0;
   gimi_task_s tk = '0;
   gimi_exit_s ex;
   gimi_fault_e flt;
   int num_errors = 0, n_checks = 0;
   logic [3:0] fin [4] = '{4'b0100, 4'b1000, 4'b1111, 4'b1100};
   logic [1:0] fex [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
   always #50 clk = ~clk;
   gimi_unit gimi_unit_inst (
      .core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .guest_entry_in(ev[0]), .ext_int_in(ev[1]),
      .physical_maskable_interrupt_in(ev[2]), .nmi_in(ev[3]),
      .smi_in(ev[4]), .smi_external_in(ext_src), .smi_in_io_in(in_io),
      .smi_io_in(io), .init_in(ev[5]), .virt_int_in(ev[6]),
      .task_switch_in(ev[7]), .task_in(tk), .ferr_freeze_in(ev[8]),
      .ignore_float_error_input(1'b0), .legacy_ferr_in(1'b1),
      .shutdown_in(ev[9]), .pause_in(ev[10]),
      .interrupt_enable_set_instruction_in(ev[11]),
      .hidden_state_op_in(ev[12]), .sysmgmt_lock_bit_in(lock),
      .current_privilege_level_in(current_privilege_level), .protected_mode_in(prot),
      .virtualization_enable_bit_in(virt), .exit_out(ex),
      .take_int_out(take), .ext_int_pending_out(extp),
      .virt_int_pending_out(virtp), .shutdown_out(shut), .fault_out(flt)
   );
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'b1);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic fire(input logic [12:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 13'h0;
      #1;
   endtask : fire
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, `GIMI_OFF_CTRL, 32'h0);
      chk({er, rd}, 33'h0);
      apb(1'b1, `GIMI_OFF_CTRL, 32'h3ff);
      apb(1'b0, `GIMI_OFF_CTRL, 32'h0);
      chk({er, rd}, 33'h3ff);
      apb(1'b0, 8'h28, 32'h0);
      chk({er, rd}, 33'h1_0000_0000);
      apb(1'b1, `GIMI_OFF_EW1_LO, 32'h5a);
      chk(er, 1'b1);
      $display("Register test done");
      for (int i = 1; i < 10; i++) begin
         fire(13'(1 << i));
         chk({ex.valid, ex.code}, {1'b1, 4'(i)});
      end
      chk({extp, virtp, shut}, 3'b110);
      $display("Intercept code test done");
      io <= '{16'h1234, 4'ha, 1'b1, 3'b010, 3'b100, 1'b1, 1'b0, 1'b1,
              3'h5, 64'h0000_7fff_0000_1230};
      ext_src <= 1'b1;
      in_io <= 1'b1;
      fire(13'h10);
      chk(ex.first_exit_word, 64'h1234_a94b_0000_1401);
      chk(ex.second_exit_word, 64'h0000_7fff_0000_1230);
      apb(1'b0, `GIMI_OFF_EW1_HI, 32'h0);
      chk({er, rd}, 33'h0_1234_a94b);
      ext_src <= 1'b0;
      in_io <= 1'b0;
      fire(13'h10);
      chk({ex.valid, ex.first_exit_word[0]}, 2'b10);
      lock <= 1'b1;
      fire(13'h10);
      chk(ex.valid, 1'b0);
      lock <= 1'b0;
      $display("System management test done");
      tk <= '{16'h0028, 32'h0000_0abc, 1'b1, 1'b0, 1'b1, 1'b1};
      fire(13'h80);
      chk(ex.first_exit_word[15:0], 16'h0028);
      chk(ex.second_exit_word, 64'h0001_1040_0000_0abc);
      tk <= '{16'h0030, 32'h0, 1'b0, 1'b1, 1'b0, 1'b0};
      fire(13'h80);
      chk(ex.second_exit_word, 64'h0000_0010_0000_0000);
      $display("Task switch test done");
      apb(1'b1, `GIMI_OFF_PFC, 32'h3);
      fire(13'h1);
      for (int i = 0; i < 3; i++) begin
         fire(13'h400);
         chk(ex.valid, i == 2);
      end
      apb(1'b1, `GIMI_OFF_PFC, 32'h0);
      fire(13'h1);
      fire(13'h400);
      chk(ex.valid, 1'b1);
      apb(1'b1, `GIMI_OFF_PFC, 32'h1);
      apb(1'b1, `GIMI_OFF_PFT, 32'h5);
      fire(13'h1);
      for (int i = 0; i < 2; i++) begin
         repeat (10) @(posedge clk);
         fire(13'h400);
         chk(ex.valid, 1'b0);
      end
      fire(13'h400);
      fire(13'h400);
      chk(ex.valid, 1'b1);
      $display("Pause filter test done");
      for (int i = 0; i < 4; i++) begin
         {prot, virt, current_privilege_level} <= fin[i];
         fire(13'h1000);
         chk(flt, fex[i]);
      end
      apb(1'b1, `GIMI_OFF_CTRL, 32'h0);
      fire(13'h200);
      chk({ex.valid, shut}, 2'b01);
      fire(13'h2);
      chk({ex.valid, take}, 2'b01);
      $display("Fault and disabled test done");
      complete_run();
   end
endmodule : test_guest_interrupt_misc_intercepts
